// ===== hw/lcm_defs.svh
// Register offsets, field positions, reset values for the logic cell block
`ifndef LCM_DEFS_SVH
`define LCM_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LCM_CFG_ADDR        12'h000
`define LCM_LUT_ADDR        12'h004
`define LCM_STAT_ADDR       12'h008

// ****************************************************************
// Configuration fields
// ****************************************************************
`define LCM_CFG_OPM         0
`define LCM_CFG_CPM         2
`define LCM_CFG_RSTEN       5
`define LCM_CFG_CARRYSEL    6
`define LCM_CFG_LOCSEL      7
`define LCM_CFG_ROWSEL      8
`define LCM_CFG_REGSRC      9
`define LCM_CFG_CASEN       10
`define LCM_CFG_MASK        32'h0000_07ff

// ****************************************************************
// Reset values
// ****************************************************************
`define LCM_CFG_RST         32'h0000_0000
`define LCM_LUT_RST         16'h0000
`define LCM_SYNC_RST        3'h7

`endif

// ===== hw/lcm_pkg.sv
// Types shared by the logic cell block
package lcm_pkg;

  typedef enum logic [1:0] {
    LCM_OP_NORMAL = 2'h0,
    LCM_OP_ARITH  = 2'h1,
    LCM_OP_UPDN   = 2'h2,
    LCM_OP_CLRCNT = 2'h3
  } lcm_op_e;

  typedef enum logic [2:0] {
    LCM_CP_CLR    = 3'h0,
    LCM_CP_PRE    = 3'h1,
    LCM_CP_CLRPRE = 3'h2,
    LCM_CP_LDCLR  = 3'h3,
    LCM_CP_LDPRE  = 3'h4,
    LCM_CP_LDONLY = 3'h5
  } lcm_cp_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lcm_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } lcm_apb_rsp_s;

  typedef struct packed {
    logic data_a;
    logic data_b;
    logic load_source_input;
    logic direct_register_input;
    logic carry_in;
    logic cascade_in;
    logic group_control_a;
    logic group_control_b;
    logic clk_en;
  } lcm_cell_in_s;

  typedef struct packed {
    logic local_out;
    logic row_out;
    logic carry_out;
    logic cascade_out;
  } lcm_cell_out_s;

  typedef struct packed {
    logic [31:0] cfg;
    logic [15:0] lut;
    logic [31:0] rdata;
    logic        store;
    logic [2:0]  rst_sync;
    logic        rst_lvl;
  } lcm_state_s;

endpackage : lcm_pkg

// ===== hw/lcm_cell.sv
// Configurable logic cell with lookup, carry, cascade and register
`timescale 1ns/1ps
`include "lcm_defs.svh"
// Operation
// - Normal mode: four-input lookup, carry-in or load source selectable as input.
// - Normal mode: lookup output ANDed with cascade-in drives cascade-out.
// - Local and row outputs each independently pick register or lookup.
// - Direct register input can load register while lookup runs separately.
// - Packed register still obeys clock enable, clear and preset.
// - Arithmetic: two three-input lookups give sum and carry-out.
// - Arithmetic mode may use cascade chain together with carry chain.
// - Up/down counter: enable, direction, 2-to-1 load mux, fast carry.
// - Counter modes load asynchronously through clear and preset.
// - Clearable counter: cascade-in is synchronous clear ANDed after load mux.
// - Emulated tri-state bus: contention gives low, no driver gives high.
// - Internal clear and preset are active low; unused ones stay high.
// - Six asynchronous clear/preset/load modes chosen by configuration.
// - Enabled chip-wide reset overrides all; inverted registers read preset.
// - Clear mode: either group control clears, preset held inactive.
// - Preset mode: group control a loads a one.
// - Clear plus preset: control a sets, control b clears.
// - Load with clear: a loads load source, b only clears.
// - Load with preset: stored inverted, b presets, a loads.
// - Load only: a copies load source into register.
// - Register updates only on edges where clock enable is true or a clear, preset or chip reset is active.

module lcm_cell #(
  parameter int TRI_N = 4
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Register bus
  input  wire lcm_pkg::lcm_apb_req_s apb_req,
  output      lcm_pkg::lcm_apb_rsp_s apb_rsp,
  // Cell data and controls from the cluster
  input  wire lcm_pkg::lcm_cell_in_s cell_in,
  output      lcm_pkg::lcm_cell_out_s cell_out,
  // Chip-wide reset pin
  input  wire logic                  chip_reset_n,
  // Emulated internal tri-state bus
  input  wire logic [TRI_N-1:0]      tri_data,
  input  wire logic [TRI_N-1:0]      tri_oe,
  output      logic                  tri_bus
);
  import lcm_pkg::*;

  if (TRI_N < 1 || TRI_N > 16) begin : g_check
    $error("TRI_N must lie between 1 and 16");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic lut_pick(input logic [15:0] tab, input logic [3:0] idx);
    return tab[idx];
  endfunction : lut_pick

  // Contention and float resolve to fixed levels instead of X or Z
  function automatic logic tri_resolve(input logic [TRI_N-1:0] d,
                                       input logic [TRI_N-1:0] oe);
    logic [4:0] cnt;
    cnt = 5'h00;
    for (int i = 0; i < TRI_N; i++) begin
      cnt = cnt + {4'h0, oe[i]};
    end
    if (cnt == 5'h00) begin
      return 1'b1;
    end else if (cnt > 5'h01) begin
      return 1'b0;
    end else begin
      return |(d & oe);
    end
  endfunction : tri_resolve

  // ****************************************************************
  // State
  // ****************************************************************
  lcm_state_s s_q;
  lcm_state_s s_d;

  localparam lcm_state_s STATE_RST = '{
    cfg:      `LCM_CFG_RST,
    lut:      `LCM_LUT_RST,
    rdata:    32'h0000_0000,
    store:    1'b0,
    rst_sync: `LCM_SYNC_RST,
    rst_lvl:  1'b0
  };

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  lcm_op_e op;
  lcm_cp_e cp;
  logic    rst_en;
  logic    carry_sel;
  logic    loc_sel;
  logic    row_sel;
  logic    reg_src;
  logic    cas_en;

  assign op        = lcm_op_e'(s_q.cfg[`LCM_CFG_OPM +: 2]);
  assign cp        = lcm_cp_e'(s_q.cfg[`LCM_CFG_CPM +: 3]);
  assign rst_en    = s_q.cfg[`LCM_CFG_RSTEN];
  assign carry_sel = s_q.cfg[`LCM_CFG_CARRYSEL];
  assign loc_sel   = s_q.cfg[`LCM_CFG_LOCSEL];
  assign row_sel   = s_q.cfg[`LCM_CFG_ROWSEL];
  assign reg_src   = s_q.cfg[`LCM_CFG_REGSRC];
  assign cas_en    = s_q.cfg[`LCM_CFG_CASEN];

  // ****************************************************************
  // Asynchronous clear, preset and load
  // ****************************************************************
  logic ga;
  logic gb;
  logic lsi;
  logic inv;
  logic clr_req;
  logic pre_req;
  logic clear_n;
  logic preset_n;
  logic chip_rst;
  logic ovr;
  logic store_eff;
  logic cell_reg;

  assign ga  = cell_in.group_control_a;
  assign gb  = cell_in.group_control_b;
  assign lsi = cell_in.load_source_input;
  // Load-with-preset keeps the bit inverted so clear acts as preset
  assign inv = (cp == LCM_CP_LDPRE);

  always_comb begin
    clr_req = 1'b0;
    pre_req = 1'b0;
    case (cp)
      LCM_CP_CLR: begin
        clr_req = ga | gb;
      end
      LCM_CP_PRE: begin
        pre_req = ga;
      end
      LCM_CP_CLRPRE: begin
        pre_req = ga;
        clr_req = gb;
      end
      LCM_CP_LDCLR: begin
        pre_req = ga & lsi;
        clr_req = (ga & ~lsi) | gb;
      end
      LCM_CP_LDPRE: begin
        pre_req = ga & ~lsi;
        clr_req = (ga & lsi) | gb;
      end
      LCM_CP_LDONLY: begin
        pre_req = ga & lsi;
        clr_req = ga & ~lsi;
      end
      default: clr_req = 1'b0;
    endcase
  end

  // Unused control stays high, so inactive
  assign clear_n  = ~clr_req;
  assign preset_n = ~pre_req;
  assign chip_rst = rst_en & s_q.rst_lvl;
  assign ovr      = chip_rst | ~clear_n | ~preset_n;

  // Override shows at once; the flop catches it at the next edge
  always_comb begin
    if (chip_rst) begin
      store_eff = 1'b0;
    end else if (!clear_n) begin
      store_eff = 1'b0;
    end else if (!preset_n) begin
      store_eff = 1'b1;
    end else begin
      store_eff = s_q.store;
    end
  end

  assign cell_reg = store_eff ^ inv;

  // ****************************************************************
  // Lookup, carry and cascade
  // ****************************************************************
  logic [3:0] nidx;
  logic [2:0] aidx;
  logic       cnt_bit;
  logic       ld_bit;
  logic       up;
  logic       lut_out;
  logic       carry_out;
  logic       cascade_out;
  logic       next_val;

  assign nidx    = {cell_in.direct_register_input,
                    carry_sel ? cell_in.carry_in : lsi,
                    cell_in.data_b, cell_in.data_a};
  assign aidx    = {cell_in.carry_in, cell_in.data_b, cell_in.data_a};
  // Counter: data_a enables counting, data_b selects the load
  assign cnt_bit = cell_reg ^ (cell_in.data_a & cell_in.carry_in);
  assign ld_bit  = cell_in.data_b ? lsi : cnt_bit;
  assign up      = (op == LCM_OP_UPDN) ? cell_in.cascade_in : 1'b1;

  always_comb begin
    case (op)
      LCM_OP_NORMAL: begin
        lut_out   = lut_pick(s_q.lut, nidx);
        carry_out = 1'b0;
      end
      LCM_OP_ARITH: begin
        lut_out   = lut_pick(s_q.lut, {1'b0, aidx});
        carry_out = lut_pick(s_q.lut, {1'b1, aidx});
      end
      LCM_OP_UPDN: begin
        lut_out   = ld_bit;
        carry_out = cell_in.carry_in & (up ? cell_reg : ~cell_reg);
      end
      LCM_OP_CLRCNT: begin
        lut_out   = ld_bit & cell_in.cascade_in;
        carry_out = cell_in.carry_in & cell_reg;
      end
      default: begin
        lut_out   = 1'b0;
        carry_out = 1'b0;
      end
    endcase
  end

  // Counter modes use cascade-in as a control, so no chain there
  assign cascade_out = (cas_en && (op == LCM_OP_NORMAL || op == LCM_OP_ARITH))
                       ? (lut_out & cell_in.cascade_in) : lut_out;
  assign next_val    = (op == LCM_OP_NORMAL && reg_src)
                       ? cell_in.direct_register_input : lut_out;

  assign cell_out.local_out   = loc_sel ? cell_reg : lut_out;
  assign cell_out.row_out     = row_sel ? cell_reg : lut_out;
  assign cell_out.carry_out   = carry_out;
  assign cell_out.cascade_out = cascade_out;
  assign tri_bus              = tri_resolve(tri_data, tri_oe);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic        setup_rd;
  logic        acc;
  logic        hit;
  logic [31:0] stat;

  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign acc      = apb_req.psel & apb_req.penable;
  assign hit      = (apb_req.paddr == `LCM_CFG_ADDR) ||
                    (apb_req.paddr == `LCM_LUT_ADDR) ||
                    (apb_req.paddr == `LCM_STAT_ADDR);
  assign stat     = {24'h00_0000, s_q.rst_lvl, tri_bus,
                     cell_out.row_out, cell_out.local_out, cascade_out,
                     carry_out, lut_out, cell_reg};

  // Zero wait state; read data was latched during setup
  assign apb_rsp.pready  = acc;
  assign apb_rsp.prdata  = s_q.rdata;
  assign apb_rsp.pslverr = acc & ~hit;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // Pin synchroniser: first stage feeds only the second
    s_d.rst_sync = {s_q.rst_sync[1:0], chip_reset_n};
    if (s_q.rst_sync[1] == s_q.rst_sync[2]) begin
      s_d.rst_lvl = ~s_q.rst_sync[2];
    end
    if (setup_rd) begin
      case (apb_req.paddr)
        `LCM_CFG_ADDR:  s_d.rdata = s_q.cfg;
        `LCM_LUT_ADDR:  s_d.rdata = {16'h0000, s_q.lut};
        `LCM_STAT_ADDR: s_d.rdata = stat;
        default:        s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && apb_req.pwrite) begin
      if (apb_req.paddr == `LCM_CFG_ADDR) begin
        s_d.cfg = apb_req.pwdata & `LCM_CFG_MASK;
      end
      if (apb_req.paddr == `LCM_LUT_ADDR) begin
        s_d.lut = apb_req.pwdata[15:0];
      end
    end
    if (ovr) begin
      s_d.store = store_eff;
    end else if (cell_in.clk_en) begin
      s_d.store = next_val ^ inv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_clr_mode;
    (cp == LCM_CP_CLR) && (ga || gb) && !chip_rst |-> !cell_reg ##1 !s_q.store;
  endproperty
  a_clr_mode: assert property (p_clr_mode) else $error("clear mode failed");

  property p_clrpre;
    (cp == LCM_CP_CLRPRE) && ga && !gb && !chip_rst |-> cell_reg ##1 s_q.store;
  endproperty
  a_clrpre: assert property (p_clrpre) else $error("preset by a failed");

  property p_ldonly;
    (cp == LCM_CP_LDONLY) && ga && !chip_rst |-> cell_reg == lsi;
  endproperty
  a_ldonly: assert property (p_ldonly) else $error("async load failed");

  property p_ldpre;
    (cp == LCM_CP_LDPRE) && gb && !chip_rst |-> cell_reg && !store_eff;
  endproperty
  a_ldpre: assert property (p_ldpre) else $error("inverted preset failed");

  property p_chip_rst;
    rst_en && s_q.rst_lvl |-> !store_eff ##1 !s_q.store;
  endproperty
  a_chip_rst: assert property (p_chip_rst) else $error("chip reset ignored");

  property p_hold;
    !ovr && !cell_in.clk_en |=> s_q.store == $past(s_q.store);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without enable");

  property p_capture;
    !ovr && cell_in.clk_en |=> s_q.store == $past(next_val ^ inv);
  endproperty
  a_capture: assert property (p_capture) else $error("register missed capture");

  property p_sync_clr;
    (op == LCM_OP_CLRCNT) && !cell_in.cascade_in |-> !lut_out;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("sync clear failed");

  property p_tri;
    ($countones(tri_oe) == 0 |-> tri_bus) and ($countones(tri_oe) > 1 |-> !tri_bus);
  endproperty
  a_tri: assert property (p_tri) else $error("tri-state emulation wrong");

  property p_arith_carry;
    op == LCM_OP_ARITH |-> carry_out == s_q.lut[{1'b1, aidx}];
  endproperty
  a_arith_carry: assert property (p_arith_carry) else $error("carry-out wrong");

  property p_cascade;
    cas_en && (op == LCM_OP_NORMAL) && !cell_in.cascade_in |-> !cell_out.cascade_out;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade AND failed");

endmodule : lcm_cell

// ===== tb/lcm_nbr.sv
// Behavioural lower-order neighbour cell driving the carry and cascade chains
`timescale 1ns/1ps
module lcm_nbr (
  // Neighbour lookup inputs
  input  wire logic nb_a,
  input  wire logic nb_b,
  input  wire logic nb_cin,
  input  wire logic nb_cas_src,
  // Chain outputs towards the cell
  output      logic carry_out,
  output      logic cascade_out
);
  // Full-adder carry of the lower bit; its cascade is the end of its own chain
  assign carry_out   = (nb_a & nb_b) | (nb_cin & (nb_a ^ nb_b));
  assign cascade_out = nb_cas_src;
endmodule : lcm_nbr

// ===== tb/logic_cell_modes_ctrl_tb.sv
// Self-checking testbench for the logic cell block
`timescale 1ns/1ps
`include "lcm_defs.svh"
module logic_cell_modes_ctrl_tb;
  import lcm_pkg::*;
  typedef struct packed {
    logic [11:0] cfg;
    logic [15:0] lut;
    logic [5:0]  in;
    logic [3:0]  mask;
    logic [3:0]  exp;
  } lcm_row_s;
  logic          pclk;
  logic          presetn;
  logic          chip_reset_n;
  lcm_apb_req_s  req;
  lcm_apb_rsp_s  rsp;
  lcm_cell_in_s  ci;
  lcm_cell_in_s  cin_w;
  lcm_cell_out_s co;
  logic [3:0]    tri_data;
  logic [3:0]    tri_oe;
  logic          tri_bus;
  logic          nb_a;
  logic          nb_b;
  logic          nb_cas;
  logic          nb_carry;
  logic          nb_casc;
  logic [31:0]   rd;
  logic          err;
  int            n_fail;
  int            n_checks;
  int            cyc = 0;
  // Inputs a b ls dri carry cas; outputs local row carry cascade
  lcm_row_s rows [8] = '{
    '{12'h000, 16'h8000, 6'b111100, 4'b1110, 4'b1100},
    '{12'h000, 16'h8000, 6'b110100, 4'b1110, 4'b0000},
    '{12'h040, 16'h8000, 6'b110110, 4'b1110, 4'b1100},
    '{12'h400, 16'hffff, 6'b000000, 4'b1111, 4'b1100},
    '{12'h400, 16'hffff, 6'b000001, 4'b1111, 4'b1101},
    '{12'h001, 16'he896, 6'b110000, 4'b1110, 4'b0010},
    '{12'h001, 16'he896, 6'b100010, 4'b1110, 4'b0010},
    '{12'h401, 16'he896, 6'b100001, 4'b1111, 4'b1101}};
  // Output enables, data, expected bus level
  logic [8:0] trows [6] = '{9'b0000_1010_1, 9'b0100_0100_1, 9'b0100_1011_0,
                            9'b0110_1111_0, 9'b1000_1000_1, 9'b1111_1111_0};
  // Clear/preset mode, initial value, control a, control b, load source, result
  logic [7:0] arows [12] = '{8'b000_11000, 8'b000_10100, 8'b001_01011, 8'b010_01011,
                             8'b010_10100, 8'b011_01011, 8'b011_11000, 8'b011_10100,
                             8'b100_00101, 8'b100_11000, 8'b101_01011, 8'b101_11000};

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  always_comb begin
    cin_w            = ci;
    cin_w.carry_in   = nb_carry;
    cin_w.cascade_in = nb_casc;
  end

  lcm_nbr u_nbr (.nb_a(nb_a), .nb_b(nb_b), .nb_cin(1'b0), .nb_cas_src(nb_cas),
                 .carry_out(nb_carry), .cascade_out(nb_casc));

  lcm_cell #(.TRI_N(4)) DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .cell_in(cin_w), .cell_out(co), .chip_reset_n(chip_reset_n), .tri_data(tri_data),
    .tri_oe(tri_oe), .tri_bus(tri_bus));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    // Wait is cut short by the global cycle ceiling
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd           = rsp.prdata;
    err          = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic set_chain(input logic carry, input logic cas);
    nb_a   <= carry;
    nb_b   <= carry;
    nb_cas <= cas;
  endtask : set_chain

  // Loads the register from the direct input; needs the direct source selected
  task automatic setreg(input logic v);
    @(posedge pclk);
    ci.direct_register_input <= v;
    ci.clk_en                <= 1'b1;
    @(posedge pclk);
    ci.clk_en                <= 1'b0;
  endtask : setreg

  // One enabled counting edge, then outputs {local, carry} compared
  task automatic step(input logic [4:0] v, input logic [1:0] exp);
    @(posedge pclk);
    {ci.data_a, ci.data_b, ci.load_source_input} <= v[4:2];
    set_chain(v[1], v[0]);
    ci.clk_en <= 1'b1;
    @(posedge pclk);
    ci.clk_en <= 1'b0;
    @(negedge pclk);
    chk("count", {30'h0, co.local_out, co.carry_out}, {30'h0, exp});
  endtask : step

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    presetn      = 1'b0;
    chip_reset_n = 1'b1;
    req          = '0;
    ci           = '0;
    tri_data     = 4'h0;
    tri_oe       = 4'h0;
    nb_a         = 1'b0;
    nb_b         = 1'b0;
    nb_cas       = 1'b0;
    n_fail       = 0;
    n_checks     = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LCM_CFG_ADDR, 32'h0000_0000);
    chk("cfg_reset", rd, `LCM_CFG_RST);
    apb(1'b0, `LCM_LUT_ADDR, 32'h0000_0000);
    chk("lut_reset", rd, {16'h0000, `LCM_LUT_RST});
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, `LCM_CFG_ADDR, 32'hffff_ffff);
    apb(1'b0, `LCM_CFG_ADDR, 32'h0000_0000);
    chk("cfg_mask", rd, `LCM_CFG_MASK);
    apb(1'b1, `LCM_LUT_ADDR, 32'hffff_ffff);
    apb(1'b0, `LCM_LUT_ADDR, 32'h0000_0000);
    chk("lut_mask", rd, 32'h0000_ffff);
    foreach (rows[i]) begin
      apb(1'b1, `LCM_CFG_ADDR, {20'h0, rows[i].cfg});
      apb(1'b1, `LCM_LUT_ADDR, {16'h0, rows[i].lut});
      @(posedge pclk);
      {ci.data_a, ci.data_b, ci.load_source_input, ci.direct_register_input} <= rows[i].in[5:2];
      set_chain(rows[i].in[1], rows[i].in[0]);
      @(negedge pclk);
      chk("cell_out", {28'h0, co & rows[i].mask}, {28'h0, rows[i].exp});
    end
    foreach (trows[i]) begin
      @(posedge pclk);
      tri_oe   <= trows[i][8:5];
      tri_data <= trows[i][4:1];
      @(negedge pclk);
      chk("tri_bus", {31'h0, tri_bus}, {31'h0, trows[i][0]});
    end
    // Register packing: lookup zero on row, register on local
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_0280);
    apb(1'b1, `LCM_LUT_ADDR, 32'h0000_0000);
    @(posedge pclk);
    ci.direct_register_input <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("hold", {31'h0, co.local_out}, 32'h0000_0000);
    setreg(1'b1);
    @(negedge pclk);
    chk("packed", {30'h0, co.local_out, co.row_out}, 32'h0000_0002);
    foreach (arows[i]) begin
      apb(1'b1, `LCM_CFG_ADDR, 32'h0000_0280 | {27'h0, arows[i][7:5], 2'b00});
      setreg(arows[i][4]);
      @(posedge pclk);
      {ci.group_control_a, ci.group_control_b, ci.load_source_input} <= arows[i][3:1];
      @(negedge pclk);
      chk("async", {31'h0, co.local_out}, {31'h0, arows[i][0]});
      @(posedge pclk);
      {ci.group_control_a, ci.group_control_b} <= 2'b00;
      @(negedge pclk);
      chk("async_held", {31'h0, co.local_out}, {31'h0, arows[i][0]});
    end
    // Chip reset ignored while disabled, then overriding a preset request
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_0284);
    setreg(1'b1);
    @(posedge pclk);
    chip_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("rst_off", {31'h0, co.local_out}, 32'h0000_0001);
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_02a4);
    @(posedge pclk);
    {ci.group_control_a, ci.load_source_input} <= 2'b11;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("rst_over", {31'h0, co.local_out}, 32'h0000_0000);
    apb(1'b0, `LCM_STAT_ADDR, 32'h0000_0000);
    chk("stat_rst", {31'h0, rd[7]}, 32'h0000_0001);
    @(posedge pclk);
    ci.group_control_a <= 1'b0;
    chip_reset_n       <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_02b0);
    setreg(1'b0);
    @(posedge pclk);
    chip_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("rst_ldpre", {31'h0, co.local_out}, 32'h0000_0001);
    @(posedge pclk);
    chip_reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
    // Up/down then clearable counter, register set first so the clear has work to do
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_0280);
    setreg(1'b1);
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_0082);
    @(posedge pclk);
    ci.group_control_a <= 1'b1;
    @(negedge pclk);
    chk("cnt_clear", {31'h0, co.local_out}, 32'h0000_0000);
    @(posedge pclk);
    ci.group_control_a <= 1'b0;
    step(5'b10011, 2'b11);
    step(5'b10011, 2'b00);
    step(5'b10010, 2'b10);
    step(5'b00010, 2'b10);
    step(5'b01000, 2'b00);
    step(5'b01100, 2'b10);
    apb(1'b1, `LCM_CFG_ADDR, 32'h0000_0083);
    step(5'b01100, 2'b00);
    step(5'b01101, 2'b10);
    // Mid-run reset returns configuration and register to reset values
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LCM_CFG_ADDR, 32'h0000_0000);
    chk("cfg_rerst", rd, `LCM_CFG_RST);
    apb(1'b0, `LCM_STAT_ADDR, 32'h0000_0000);
    chk("reg_rerst", {31'h0, rd[0]}, 32'h0000_0000);
    complete_run();
  end
endmodule : logic_cell_modes_ctrl_tb
